// ---- rtl/fmwr_host.sv ----
// How it works
// RQ1: 256-colour pixel sent whole on low eight lines as 3-3-2.
// RQ2: 4k-colour pixel sent whole on low twelve lines as 4-4-4.
// RQ3: 65k-colour pixel sent whole on sixteen lines as 5-6-5.
// RQ4: 262k-colour pixel sent on eighteen lines, red on top.
// RQ5: frame write command sent with select low, pixels with it high.
// RQ6: device stores only complete pixels; partial ones are dropped.
// RQ7: video mode pixels go on the video bus into the set window.
// RQ8: video width 00 is 18-bit, 01 is 16-bit, 10 three 6-bit beats.
// RQ9: video data is captured on the pixel clock while enable is low.
// RQ10: video mode 1 paces frames to the device frame sync output.
// RQ11: video mode 2 needs a continuous vertical sync from us.
// RQ12: video mode 3 needs pixel clock, vertical and horizontal sync.
// RQ13: column addresses stay within 0..175, rows within 0..239.
// RQ14: device writes RAM once each pixel's 18-bit value is complete.
// RQ15: window is set by column set and row set before pixels.
// RQ16: with axis exchange the row pointer steps first and wraps.
// RQ17: without axis exchange the column pointer steps first and wraps.
// RQ18: after the last corner both pointers return to window start.
// RQ19: each frame write command resets pointers to window start.
// RQ20: access parameter: axis exchange bit 5, mirrors bits 6 and 7.
// RQ21: after changing direction bits the frame memory is rewritten.
// RQ22: device widens 5-bit red and blue to 6 bits before storage.
// RQ23: device expands 256 and 4k colour pixels to 6-6-6; the device model stores them as sent.
// RQ24: device mirrors pointers as max minus value, swaps on exchange.
module fmwr_host
  import fmwr_pkg::*;
#(
  parameter logic [7:0]  ACCESS_CMD = 8'h36,
  parameter logic [7:0]  INTERFACE_MODE_CMD_CMD = 8'hB0,
  parameter logic [9:0]  H_TOTAL    = 10'd200,
  parameter logic [8:0]  V_TOTAL    = 9'd250
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // user command port
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  fmwr_op_t          cmd_op,
  input  fmwr_win_t         cmd_win,
  input  fmwr_cfg_t         cmd_cfg,
  // user pixel stream
  input  wire logic         pix_valid,
  output logic              pix_ready,
  input  fmwr_pix_t         pix_data,
  input  wire logic         pix_last,
  output logic              rewrite_needed,
  // device host bus
  output logic              host_cs_n,
  output logic              host_dc,
  output logic              host_wr_n,
  output logic [17:0]       host_data,
  // device video bus
  output logic              pixel_clock_in,
  output logic              video_en_n,
  output logic              vsync_n,
  output logic              hsync_n,
  output logic [17:0]       video_data,
  input  wire logic         frame_sync_out
);

  // ****************************************************************
  // state and sequence items
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_LOW  = 4'h2,
    ST_HIGH = 4'h4,
    ST_PIX  = 4'h8
  } fmwr_state_t;

  fmwr_state_t  state_q;
  fmwr_op_t     op_q;
  fmwr_win_t    win_q;
  fmwr_cfg_t    cfg_q;
  logic [3:0]   idx_q;
  logic         item_last_q;
  logic         pix_mode_q;
  logic         pix_end_q;
  logic [19:0]  item;
  logic [17:0]  host_word;
  logic [17:0]  vid_word;

  // clamp an address to the legal range
  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  // pack a parameter byte onto the bus as {last, dc, data}
  function automatic logic [19:0] prm(input logic last, input logic [7:0] b);
    prm = {last, 1'b1, 10'h000, b};
  endfunction

  // pack a command byte, select line low
  function automatic logic [19:0] cmd(input logic last, input logic [7:0] b);
    cmd = {last, 1'b0, 10'h000, b};
  endfunction

  // ****************************************************************
  // command and parameter sequence for each operation
  // ****************************************************************
  always_comb
  begin
    item = cmd(1'b1, FMWR_CMD_FRAME_WR);
    case (op_q)
      FMWR_OP_WINDOW:
        case (idx_q)
          4'h0:    item = cmd(1'b0, FMWR_CMD_COL_SET);            // see RQ15
          4'h1:    item = prm(1'b0, 8'h00);
          4'h2:    item = prm(1'b0, win_q.col_start);
          4'h3:    item = prm(1'b0, 8'h00);
          4'h4:    item = prm(1'b0, win_q.col_end);
          4'h5:    item = cmd(1'b0, FMWR_CMD_ROW_SET);            // see RQ15
          4'h6:    item = prm(1'b0, 8'h00);
          4'h7:    item = prm(1'b0, win_q.row_start);
          4'h8:    item = prm(1'b0, 8'h00);
          default: item = prm(1'b1, win_q.row_end);
        endcase
      FMWR_OP_ACCESS:
        if (idx_q == 4'h0)
        begin
          item = cmd(1'b0, ACCESS_CMD);
        end
        else
        begin
          item = prm(1'b1, {cfg_q.row_mirror, cfg_q.column_mirror,
                            cfg_q.axis_exchange, 5'h00});         // see RQ20
        end
      FMWR_OP_INTERFACE_MODE_CMD:
        case (idx_q)
          4'h0:    item = cmd(1'b0, INTERFACE_MODE_CMD_CMD);
          4'h1:    item = prm(1'b0, {cfg_q.video_en, cfg_q.vmode, 5'h00});
          default: item = prm(1'b1, {6'h00, cfg_q.vwidth});       // see RQ8
        endcase
      FMWR_OP_FRAME:
        item = cmd(1'b1, FMWR_CMD_FRAME_WR);                      // see RQ5
      default:
        item = cmd(1'b1, FMWR_CMD_FRAME_WR);
    endcase
  end

  // ****************************************************************
  // pixel formatting
  // ****************************************************************
  fmwr_pix_t   vid_pix_q;
  logic [1:0]  vid_phase_q;
  logic        vid_more_q;
  fmwr_pix_t   vid_sel_pix;
  logic [1:0]  vid_sel_phase;

  // continuing beats reuse the latched pixel, new pixels come straight in
  assign vid_sel_pix   = vid_more_q ? vid_pix_q : pix_data;
  assign vid_sel_phase = vid_more_q ? 2'(vid_phase_q + 2'h1) : 2'h0;

  fmwr_pack u_pack (
    .host_pix  (pix_data),
    .color     (cfg_q.color),
    .bus18     (cfg_q.bus18),
    .vid_pix   (vid_sel_pix),
    .vwidth    (cfg_q.vwidth),
    .phase     (vid_sel_phase),
    .host_word (host_word),
    .vid_word  (vid_word)
  );

  // ****************************************************************
  // host bus sequencer
  // ****************************************************************
  logic host_take;
  logic vid_take;

  assign cmd_ready = (state_q == ST_IDLE);
  assign host_take = (state_q == ST_PIX) && pix_valid;
  assign pix_ready = (state_q == ST_PIX) || vid_take;

  // one strobe low cycle per transfer and at least one high cycle, two for pixels; the device
  // latches on the rising edge of the write strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_IDLE;
      idx_q       <= FMWR_RST_VALUE;
      item_last_q <= 1'b0;
      pix_mode_q  <= 1'b0;
      pix_end_q   <= 1'b0;
      host_cs_n   <= 1'b1;
      host_dc     <= 1'b1;
      host_wr_n   <= 1'b1;
      host_data   <= 18'h00000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cmd_valid)
          begin
            state_q    <= ST_LOW;
            idx_q      <= FMWR_RST_VALUE;
            pix_mode_q <= 1'b0;
            host_cs_n  <= 1'b0;
          end
          else
          begin
            host_cs_n <= 1'b1;
          end
        ST_LOW:
          begin
            host_wr_n <= 1'b0;
            if (!pix_mode_q)
            begin
              host_dc     <= item[18];                             // see RQ5
              host_data   <= item[17:0];
              item_last_q <= item[19];
            end
            state_q <= ST_HIGH;
          end
        ST_HIGH:
          begin
            host_wr_n <= 1'b1;
            idx_q     <= 4'(idx_q + 4'h1);
            if (pix_mode_q && pix_end_q)
            begin
              state_q   <= ST_IDLE;                                // whole pixels only, see RQ6
            end
            else if (pix_mode_q || (item_last_q && op_q == FMWR_OP_FRAME
                                    && !cfg_q.video_en))
            begin
              state_q <= ST_PIX;                                   // see RQ5
            end
            else if (item_last_q)
            begin
              state_q   <= ST_IDLE;
            end
            else
            begin
              state_q <= ST_LOW;
            end
          end
        ST_PIX:
          if (pix_valid)
          begin
            pix_mode_q <= 1'b1;
            pix_end_q  <= pix_last;
            host_dc    <= 1'b1;                                    // see RQ5
            host_data  <= host_word;                               // see RQ14
            state_q    <= ST_LOW;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // latch operation, window and configuration when a command is taken
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      op_q  <= FMWR_OP_WINDOW;
      win_q <= '0;
      cfg_q <= '{axis_exchange: 1'b0, column_mirror: 1'b0, row_mirror: 1'b0,
                 video_en: 1'b0, vwidth: FMWR_VW_18, vmode: FMWR_VM_1,
                 color: FMWR_CM_65K, bus18: 1'b1};
    end
    else if (cmd_ready && cmd_valid)
    begin
      op_q <= cmd_op;
      if (cmd_op == FMWR_OP_WINDOW)
      begin
        win_q.col_start <= clamp(cmd_win.col_start, FMWR_COL_MAX);  // see RQ13
        win_q.col_end   <= clamp(cmd_win.col_end, FMWR_COL_MAX);    // see RQ13
        win_q.row_start <= clamp(cmd_win.row_start, FMWR_ROW_MAX);  // see RQ13
        win_q.row_end   <= clamp(cmd_win.row_end, FMWR_ROW_MAX);    // see RQ13
      end
      if (cmd_op != FMWR_OP_WINDOW && cmd_op != FMWR_OP_FRAME)
      begin
        cfg_q <= cmd_cfg;
      end
      else
      begin
        cfg_q.color <= cmd_cfg.color;
        cfg_q.bus18 <= cmd_cfg.bus18;
      end
    end
  end

  // ****************************************************************
  // rewrite reminder
  // ****************************************************************
  // set when the access command is taken, cleared by a finished frame; the
  // set wins so a new direction change is never lost
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rewrite_needed <= 1'b0;
    end
    else if (cmd_ready && cmd_valid && cmd_op == FMWR_OP_ACCESS)
    begin
      rewrite_needed <= 1'b1;                                      // see RQ21
    end
    else if (pix_ready && pix_valid && pix_last)
    begin
      rewrite_needed <= 1'b0;
    end
  end

  // ****************************************************************
  // pixel clock divider
  // ****************************************************************
  logic [3:0] div_q;
  logic       dck_wrap;
  logic       dck_fall;

  assign dck_wrap = (div_q == 4'(FMWR_DCK_HALF_CYC - 4'h1));
  assign dck_fall = dck_wrap && pixel_clock_in;

  // we make the pixel clock, so it shares mclk's domain
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_q          <= FMWR_RST_VALUE;
      pixel_clock_in <= 1'b0;
    end
    else
    begin
      div_q <= dck_wrap ? FMWR_RST_VALUE : 4'(div_q + 4'h1);
      if (dck_wrap)
      begin
        pixel_clock_in <= ~pixel_clock_in;
      end
    end
  end

  // ****************************************************************
  // sync generation for video modes 2 and 3
  // ****************************************************************
  logic [9:0] h_cnt_q;
  logic [8:0] v_cnt_q;
  logic       ext_sync;
  logic       frame_top;

  assign ext_sync  = cfg_q.video_en && (cfg_q.vmode != FMWR_VM_1);
  assign frame_top = dck_fall && (h_cnt_q == 10'(H_TOTAL - 10'h001))
                     && (v_cnt_q == 9'(V_TOTAL - 9'h001));

  // free running so the device sees its syncs continuously in video modes 2 and 3
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      h_cnt_q <= 10'h000;
      v_cnt_q <= 9'h000;
      vsync_n <= 1'b1;
      hsync_n <= 1'b1;
    end
    else if (dck_fall)
    begin
      if (h_cnt_q == 10'(H_TOTAL - 10'h001))
      begin
        h_cnt_q <= 10'h000;
        v_cnt_q <= (v_cnt_q == 9'(V_TOTAL - 9'h001)) ? 9'h000 : 9'(v_cnt_q + 9'h001);
      end
      else
      begin
        h_cnt_q <= 10'(h_cnt_q + 10'h001);
      end
      vsync_n <= !(ext_sync && frame_top);                          // see RQ11
      hsync_n <= !(ext_sync && cfg_q.vmode == FMWR_VM_3
                   && h_cnt_q == 10'(H_TOTAL - 10'h001));           // see RQ12
    end
  end

  // ****************************************************************
  // frame sync input crossing and frame gate
  // ****************************************************************
  logic fs_meta_q;
  logic fs_sync_q;
  logic fs_prev_q;
  logic frame_go_q;
  logic frame_start;

  // device frame sync is asynchronous; two flops before any use
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      fs_meta_q <= 1'b0;
      fs_sync_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end
    else
    begin
      fs_meta_q <= frame_sync_out;
      fs_sync_q <= fs_meta_q;
      fs_prev_q <= fs_sync_q;
    end
  end

  assign frame_start = cfg_q.video_en &&
                       ((cfg_q.vmode == FMWR_VM_1) ? (fs_sync_q && !fs_prev_q)  // see RQ10
                                                   : frame_top);

  // a frame opens on its sync and closes with the last pixel; start wins
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      frame_go_q <= 1'b0;
    end
    else if (frame_start)
    begin
      frame_go_q <= 1'b1;
    end
    else if (!cfg_q.video_en || (vid_take && pix_valid && pix_last))
    begin
      frame_go_q <= 1'b0;
    end
  end

  // ****************************************************************
  // video bus beats
  // ****************************************************************
  // a new pixel is taken only at a clock fall with no beats pending,
  // so a 6-bit pixel is never cut short
  assign vid_take = cfg_q.video_en && frame_go_q && dck_fall && !vid_more_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      vid_pix_q   <= '0;
      vid_phase_q <= 2'h0;
      vid_more_q  <= 1'b0;
      video_en_n  <= 1'b1;
      video_data  <= 18'h00000;
    end
    else if (dck_fall)
    begin
      if (vid_more_q)
      begin
        vid_phase_q <= vid_sel_phase;
        video_data  <= vid_word;                                   // see RQ8
        video_en_n  <= 1'b0;
        vid_more_q  <= (vid_sel_phase != 2'h2);
      end
      else if (vid_take && pix_valid)
      begin
        vid_pix_q   <= pix_data;
        vid_phase_q <= 2'h0;
        video_data  <= vid_word;                                   // see RQ7
        video_en_n  <= 1'b0;                                       // see RQ9
        vid_more_q  <= (cfg_q.vwidth == FMWR_VW_6);
      end
      else
      begin
        video_en_n <= 1'b1;
      end
    end
  end

endmodule

// ---- rtl/fmwr_pkg.sv ----
package fmwr_pkg;

  // ****************************************************************
  // command codes and address limits
  // ****************************************************************
  localparam logic [7:0] FMWR_CMD_COL_SET   = 8'h2A;  // column_window_set
  localparam logic [7:0] FMWR_CMD_ROW_SET   = 8'h2B;  // row_window_set
  localparam logic [7:0] FMWR_CMD_FRAME_WR  = 8'h2C;  // frame_write_command
  localparam logic [7:0] FMWR_COL_MAX       = 8'hAF;  // last legal column
  localparam logic [7:0] FMWR_ROW_MAX       = 8'hEF;  // last legal row

  // ****************************************************************
  // field positions in the access direction parameter
  // ****************************************************************
  localparam int FMWR_AXIS_BIT = 5;
  localparam int FMWR_COLM_BIT = 6;
  localparam int FMWR_ROWM_BIT = 7;
  // interface mode parameter fields
  localparam int FMWR_IF_VIDEO_BIT = 7;
  localparam int FMWR_IF_VMODE_LSB = 5;

  // ****************************************************************
  // timing values in ns and counts in mclk cycles
  // ****************************************************************
  localparam int          FMWR_MCLK_NS      = 100;
  localparam int          FMWR_DCK_HALF_NS  = 200;
  localparam logic [3:0]  FMWR_DCK_HALF_CYC = 4'((FMWR_DCK_HALF_NS + FMWR_MCLK_NS - 1)
                                              / FMWR_MCLK_NS);
  localparam logic [3:0]  FMWR_RST_VALUE    = 4'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    FMWR_CM_256  = 2'h0,
    FMWR_CM_4K   = 2'h1,
    FMWR_CM_65K  = 2'h2,
    FMWR_CM_262K = 2'h3
  } fmwr_color_t;

  typedef enum logic [1:0] {
    FMWR_VW_18 = 2'h0,
    FMWR_VW_16 = 2'h1,
    FMWR_VW_6  = 2'h2
  } fmwr_vwidth_t;

  typedef enum logic [1:0] {
    FMWR_VM_1 = 2'h1,
    FMWR_VM_2 = 2'h2,
    FMWR_VM_3 = 2'h3
  } fmwr_vmode_t;

  typedef enum logic [1:0] {
    FMWR_OP_WINDOW = 2'h0,
    FMWR_OP_ACCESS = 2'h1,
    FMWR_OP_INTERFACE_MODE_CMD = 2'h2,
    FMWR_OP_FRAME  = 2'h3
  } fmwr_op_t;

  typedef struct packed {
    logic [7:0] col_start;
    logic [7:0] col_end;
    logic [7:0] row_start;
    logic [7:0] row_end;
  } fmwr_win_t;

  typedef struct packed {
    logic         axis_exchange;
    logic         column_mirror;
    logic         row_mirror;
    logic         video_en;
    fmwr_vwidth_t vwidth;
    fmwr_vmode_t  vmode;
    fmwr_color_t  color;
    logic         bus18;
  } fmwr_cfg_t;

  typedef struct packed {
    logic [5:0] r;
    logic [5:0] g;
    logic [5:0] b;
  } fmwr_pix_t;

endpackage

// ---- rtl/fmwr_pack.sv ----
module fmwr_pack
  import fmwr_pkg::*;
(
  input  fmwr_pix_t    host_pix,
  input  fmwr_color_t  color,
  input  wire logic    bus18,
  input  fmwr_pix_t    vid_pix,
  input  fmwr_vwidth_t vwidth,
  input  wire logic [1:0] phase,
  output logic [17:0]  host_word,
  output logic [17:0]  vid_word
);

  // ****************************************************************
  // host bus packing: one whole pixel per transfer
  // ****************************************************************
  // 262k needs all 18 lines; on a 16-bit bus it falls back to 5-6-5
  always_comb
  begin
    case (color)
      FMWR_CM_256:
        host_word = {10'h000, host_pix.r[5:3], host_pix.g[5:3], host_pix.b[5:4]}; // see RQ1
      FMWR_CM_4K:
        host_word = {6'h00, host_pix.r[5:2], host_pix.g[5:2], host_pix.b[5:2]};  // see RQ2
      FMWR_CM_262K:
        if (bus18)
        begin
          host_word = {host_pix.r, host_pix.g, host_pix.b};                       // see RQ4
        end
        else
        begin
          host_word = {2'h0, host_pix.r[5:1], host_pix.g, host_pix.b[5:1]};
        end
      default:
        host_word = {2'h0, host_pix.r[5:1], host_pix.g, host_pix.b[5:1]};        // see RQ3
    endcase
  end

  // ****************************************************************
  // video bus packing by bus width
  // ****************************************************************
  always_comb
  begin
    case (vwidth)
      FMWR_VW_16:
        vid_word = {vid_pix.r[5:1], 1'b0, vid_pix.g, vid_pix.b[5:1], 1'b0}; // see RQ8
      FMWR_VW_6:
        case (phase)
          2'h0:    vid_word = {12'h000, vid_pix.r};                         // see RQ8
          2'h1:    vid_word = {12'h000, vid_pix.g};
          default: vid_word = {12'h000, vid_pix.b};
        endcase
      default:
        vid_word = {vid_pix.r, vid_pix.g, vid_pix.b};                       // see RQ7
    endcase
  end

endmodule

// ---- testbench/fmwr_host_sva.sv ----
module fmwr_host_sva
  import fmwr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        host_cs_n,
  input wire logic        host_dc,
  input wire logic        host_wr_n,
  input wire logic [17:0] host_data,
  input wire logic        pixel_clock_in,
  input wire logic        video_en_n,
  input wire logic [17:0] video_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // bus checks
  // ********
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a sequence opens with a command beat
  sequence s_cmd_beat;
    host_wr_n ##1 (!host_wr_n && !host_dc);
  endsequence
  sequence s_high_half;
    pixel_clock_in ##1 !pixel_clock_in;
  endsequence
  a_req_taken: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("command not taken");
  a_cmd_first: assert property (cmd_valid && cmd_ready |=> s_cmd_beat)
    else $error("command beat missing");
  a_wr_in_cs: assert property (!host_wr_n |-> !host_cs_n)
    else $error("strobe outside select");
  a_wr_pulse: assert property ($fell(host_wr_n) |=> host_wr_n)
    else $error("strobe too long");
  a_data_hold: assert property ($rose(host_wr_n) |-> $stable(host_data) && $stable(host_dc))
    else $error("data moved at strobe");
  a_pclk_half: assert property ($rose(pixel_clock_in) |=> s_high_half)
    else $error("pixel clock half wrong");
  a_beat_len: assert property ($fell(video_en_n) |=> !video_en_n [*3])
    else $error("video beat short");
  a_beat_stable: assert property (!video_en_n && pixel_clock_in |-> $stable(video_data))
    else $error("video data moved");
endmodule

bind fmwr_host fmwr_host_sva u_sva (.mclk, .rst_n, .cmd_valid, .cmd_ready, .host_cs_n,
  .host_dc, .host_wr_n, .host_data, .pixel_clock_in, .video_en_n, .video_data);

// ---- testbench/fmwr_dev_model.sv ----
module fmwr_dev_model
  import fmwr_pkg::*;
(
  input wire logic        mclk,
  input wire logic        host_cs_n,
  input wire logic        host_dc,
  input wire logic        host_wr_n,
  input wire logic [17:0] host_data,
  input wire logic        pixel_clock_in,
  input wire logic        video_en_n,
  input wire logic [17:0] video_data,
  input fmwr_color_t      color,
  output logic            frame_sync_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // device model
  // ********
  logic [7:0]  cmd_q, cs_q, ce_q, rs_q, re_q, cx_q, cy_q, col_q, row_q;
  logic [17:0] raw_q, mem_q, acc_q;
  logic [5:0]  fc_q = 6'h00;
  logic [1:0]  vw_q = 2'h0;
  logic        mv_q = 1'b0;
  logic [1:0]  mir_q = 2'h0;
  int          vb_q = 0;
  int          n_q = 0;
  int          idx_q;
  // own frame timing
  always @(posedge mclk)
  begin
    fc_q <= fc_q + 6'h01;
    frame_sync_out <= (fc_q[5:1] == 5'h00);
  end
  // one ram write per whole pixel
  task automatic store(input logic [17:0] w);
    raw_q = w;
    mem_q = (color == FMWR_CM_65K) ? {w[15:11], w[15], w[10:5], w[4:0], w[4]} : w;
    col_q = mir_q[0] ? 8'hAF - cx_q : cx_q;
    row_q = mir_q[1] ? 8'hEF - cy_q : cy_q;
    n_q++;
    if (mv_q && cy_q < re_q) cy_q++;
    else if (mv_q)
    begin
      cy_q = rs_q;
      cx_q = (cx_q < ce_q) ? cx_q + 8'h01 : cs_q;
    end
    else if (cx_q < ce_q) cx_q++;
    else
    begin
      cx_q = cs_q;
      cy_q = (cy_q < re_q) ? cy_q + 8'h01 : rs_q;
    end
  endtask
  // host bus latched on the rising strobe
  always @(posedge host_wr_n)
    if (!host_cs_n && !host_dc)
    begin
      cmd_q = host_data[7:0];
      idx_q = 0;
      if (cmd_q == 8'h2C) {cx_q, cy_q} = {cs_q, rs_q};
    end
    else if (!host_cs_n)
    begin
      if (cmd_q == 8'h2A && idx_q == 1) cs_q = host_data[7:0];
      if (cmd_q == 8'h2A && idx_q == 3) ce_q = host_data[7:0];
      if (cmd_q == 8'h2B && idx_q == 1) rs_q = host_data[7:0];
      if (cmd_q == 8'h2B && idx_q == 3) re_q = host_data[7:0];
      if (cmd_q == 8'h36) {mir_q, mv_q} = host_data[7:5];
      if (cmd_q == 8'hB0 && idx_q == 1) vw_q = host_data[1:0];
      if (cmd_q == 8'h2C) store(host_data);
      idx_q++;
    end
  // video bus: 6-bit width needs three beats
  always @(posedge pixel_clock_in)
    if (!video_en_n && vw_q == 2'h2)
    begin
      acc_q = {acc_q[11:0], video_data[5:0]};
      vb_q++;
      if (vb_q == 3) store(acc_q);
      if (vb_q == 3) vb_q = 0;
    end
    else if (!video_en_n) store(video_data);
endmodule

// ---- testbench/frame_memory_write_path_test.sv ----
module frame_memory_write_path_test
  import fmwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // bench
  // ********
  typedef struct packed {fmwr_color_t c; logic b18; logic [17:0] e;} fmwr_row_t;
  localparam logic [17:0] PIX = 18'h2D6B3;
  logic mclk = 1'b0, rst_n, cmd_valid, pix_valid, pix_last, cmd_ready, pix_ready;
  logic rewrite_needed, host_cs_n, host_dc, host_wr_n, pixel_clock_in, video_en_n;
  logic vsync_n, hsync_n, frame_sync_out;
  logic [17:0] pix_data, host_data, video_data;
  fmwr_op_t cmd_op;
  fmwr_win_t cmd_win;
  fmwr_cfg_t cmd_cfg;
  fmwr_color_t mcol;
  int err_count = 0, checks_done = 0, cyc = 0, n0;
  fmwr_row_t rows [5] = '{'{FMWR_CM_256, 1'b1, 18'h000AF}, '{FMWR_CM_4K, 1'b1, 18'h00B6C},
    '{FMWR_CM_65K, 1'b1, 18'h0B359}, '{FMWR_CM_262K, 1'b1, PIX}, '{FMWR_CM_262K, 1'b0, 18'h0B359}};

  fmwr_host #(.H_TOTAL(10'h008), .V_TOTAL(9'h004)) DUT (.mclk, .rst_n, .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_win, .cmd_cfg, .pix_valid, .pix_ready, .pix_data, .pix_last, .rewrite_needed,
    .host_cs_n, .host_dc, .host_wr_n, .host_data, .pixel_clock_in, .video_en_n, .vsync_n,
    .hsync_n, .video_data, .frame_sync_out);
  fmwr_dev_model u_dev (.mclk, .host_cs_n, .host_dc, .host_wr_n, .host_data, .pixel_clock_in,
    .video_en_n, .video_data, .color(mcol), .frame_sync_out);

  always #50 mclk = ~mclk;
  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000) err_count++;
    if (cyc == 20000) end_sim();
  end

  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [17:0] e, input logic [17:0] s);
    checks_done++;
    if (s !== e) err_count++;
    if (s !== e) $display("[ERR] %s expected %h seen %h", nm, e, s);
  endtask
  task idle;
    for (int k = 0; k < 400 && cmd_ready !== 1'b1; k++) @(negedge mclk);
    repeat (2) @(negedge mclk);
  endtask
  // request held until taken
  task cmd(input fmwr_op_t o);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = o;
    for (int k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
    if (o != FMWR_OP_FRAME) idle();
  endtask
  task pix(input logic [17:0] d, input logic l);
    @(negedge mclk);
    {pix_valid, pix_data, pix_last} = {1'b1, d, l};
    for (int k = 0; k < 500 && pix_ready !== 1'b1; k++) @(negedge mclk);
    @(negedge mclk);
    {pix_valid, pix_last} = 2'h0;
  endtask
  task burst(input int n);
    cmd(FMWR_OP_FRAME);
    for (int k = 0; k < n; k++) pix(PIX, k == n - 1);
    idle();
  endtask

  initial
  begin
    {rst_n, cmd_valid, pix_valid, pix_last, pix_data} = '0;
    {cmd_op, cmd_cfg, mcol} = '0;
    cmd_win = '{8'h00, 8'hAF, 8'h00, 8'hEF};
    repeat (5) @(negedge mclk);
    chk("reset", 18'h0002E, 18'({cmd_ready, pix_ready, host_cs_n, host_wr_n, video_en_n,
      rewrite_needed}));
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      {cmd_cfg.color, cmd_cfg.bus18} = {rows[i].c, rows[i].b18};
      mcol = rows[i].b18 ? rows[i].c : FMWR_CM_65K;
      cmd(FMWR_OP_WINDOW);
      burst(1);
      chk("bus word", rows[i].e, u_dev.raw_q);
      if (mcol == FMWR_CM_65K) chk("stored", PIX, u_dev.mem_q);
    end
    // small window: step, wrap, restart
    cmd_win = '{8'h03, 8'h04, 8'h05, 8'h06};
    cmd(FMWR_OP_WINDOW);
    burst(3);
    chk("addr", 18'h00306, {u_dev.col_q, u_dev.row_q});
    burst(5);
    chk("addr", 18'h00305, {u_dev.col_q, u_dev.row_q});
    cmd_cfg.axis_exchange = 1'b1;
    cmd(FMWR_OP_ACCESS);
    chk("rewrite", 18'h1, 18'(rewrite_needed));
    burst(3);
    chk("addr", 18'h00405, {u_dev.col_q, u_dev.row_q});
    chk("rewrite", 18'h0, 18'(rewrite_needed));
    cmd_win = '{8'h00, 8'hC8, 8'h00, 8'hF5};
    cmd(FMWR_OP_WINDOW);
    chk("clamp", 18'h0AFEF, {u_dev.ce_q, u_dev.re_q});
    // video bus in each width and sync mode
    {cmd_cfg.video_en, mcol} = {1'b1, FMWR_CM_262K};
    for (int w = 0; w < 3; w++)
    begin
      cmd_cfg.vwidth = fmwr_vwidth_t'(w);
      cmd_cfg.vmode = fmwr_vmode_t'(w + 1);
      cmd(FMWR_OP_INTERFACE_MODE_CMD);
      n0 = u_dev.n_q;
      pix(PIX, 1'b1);
      for (int k = 0; k < 100 && u_dev.n_q == n0; k++) @(negedge mclk);
      chk("stores", 18'(n0 + 1), 18'(u_dev.n_q));
      chk("video", (w == 1) ? PIX & 18'h3EFFE : PIX, u_dev.mem_q);
    end
    end_sim();
  end
endmodule
